// File: verilog/rcs_pkg.sv
// Functional notes
// - power-on clears all flags, sets brown-out and power-on, starts at reset vector
// - brown-out clears pin, soft, watchdog, sleep, idle, mismatch; sets brown-out only
// - pin reset in run sets pin flag; soft reset sets soft flag; others kept
// - pin reset while idle or asleep keeps the idle or sleep flag set
// - mismatch reset sets the mismatch flag, all others kept
// - watchdog reset in run sets the watchdog flag, all others kept
// - watchdog timeout while asleep or idle sets watchdog flag, keeps sleep or idle
// - interrupt wake goes to interrupt vector, leaving every cause flag unchanged
// - sleep and idle flags set by wait, cleared by software, power-on, brown-out
// - software may set or clear any flag; writing never causes a reset
// - every reset reloads the configuration before release
// - power-on presets every configuration word to all ones before loading
// - other resets reload configuration without presetting it first
// - every reset reselects the core clock from the boot clock select field
// - basic delay is reload time plus eight clocks; pin, mismatch, soft, watchdog use it
// - power-on waits regulator start-up or power-up timer, then basic delay
// - power-on and brown-out add lock delay for pll sources, oscillator start-up for crystal sources, clock monitor delay for either
// - arm bit write then a read of that register resets next cycle
// - watchdog timeout asleep or idle wakes to reset vector without device reset
package rcs_pkg;

  // register byte offsets
  localparam logic [3:0]  REG_FLAGS      = 4'h0;
  localparam logic [3:0]  REG_SOFT       = 4'h4;
  localparam logic [3:0]  REG_STAT       = 4'h8;

  // reset_cause_flags bit positions
  localparam int          FLG_POR        = 0;
  localparam int          FLG_BROWN      = 1;
  localparam int          FLG_IDLE       = 2;
  localparam int          FLG_SLEEP      = 3;
  localparam int          FLG_WDOG       = 4;
  localparam int          FLG_SOFT       = 6;
  localparam int          FLG_PIN        = 7;
  localparam int          FLG_MISM       = 9;
  localparam logic [31:0] FLAGS_WMASK    = 32'h0000_02DF;
  localparam logic [31:0] FLAGS_RST      = 32'h0000_0003;
  localparam logic [31:0] FLAGS_KEEP_PON = 32'h0000_0001;

  // status register fields
  localparam int          STAT_LP_LSB    = 4;
  localparam int          STAT_CLK_LSB   = 8;

  localparam logic [31:0] RESET_VECTOR   = 32'hBFC0_0000;
  localparam logic [31:0] IRQ_VECTOR     = 32'h0000_0200;

  // timing
  localparam int          CLK_MHZ        = 50;
  localparam int          PWRT_MS        = 64;
  localparam int          PWRT_CYC       = PWRT_MS * 1000 * CLK_MHZ;
  localparam int          VREG_US        = 10;
  localparam int          VREG_CYC       = VREG_US * CLK_MHZ;
  localparam int          LOCK_US        = 100;
  localparam int          LOCK_CYC       = LOCK_US * CLK_MHZ;
  localparam int          OST_US         = 1000;
  localparam int          OST_CYC        = OST_US * CLK_MHZ;
  localparam int          FSCM_US        = 2;
  localparam int          FSCM_CYC       = FSCM_US * CLK_MHZ;
  localparam int          SYSDLY_CLKS    = 8;

  // configuration store
  localparam int          CFG_WORDS      = 4;
  localparam int          CFG_CLK_WORD   = 1;
  localparam int          CLKSEL_LSB     = 0;
  localparam int          XTAL_BIT       = 8;
  localparam logic [31:0] CFG_PRESET     = 32'hFFFF_FFFF;
  localparam logic [2:0]  CLK_SEL_RST    = 3'h0;

  // boot clock select codes
  localparam logic [2:0]  CLK_FRCPLL     = 3'h1;
  localparam logic [2:0]  CLK_PRI        = 3'h2;
  localparam logic [2:0]  CLK_PRIPLL     = 3'h3;
  localparam logic [2:0]  CLK_SOSC       = 3'h4;

  typedef enum logic [2:0] {
    ST_RUN    = 3'h0,
    ST_HOLD   = 3'h1,
    ST_PWRUP  = 3'h2,
    ST_LOAD   = 3'h3,
    ST_CLKDLY = 3'h4,
    ST_SYSDLY = 3'h5
  } rcs_state_t;

  typedef enum logic [1:0] {
    LP_RUN   = 2'h0,
    LP_IDLE  = 2'h1,
    LP_SLEEP = 2'h2
  } rcs_lp_t;

endpackage : rcs_pkg

// File: verilog/rcs_cfg_loader.sv
`timescale 1ns/1ns
`default_nettype none
module rcs_cfg_loader #(
  parameter int WORDS = rcs_pkg::CFG_WORDS,
  parameter int AW    = 2
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  // control
  input  wire logic          start_i,
  input  wire logic          preset_i,
  output logic               done_o,
  output logic               mismatch_o,
  // nonvolatile store
  output logic               cfg_rd_o,
  output logic [AW-1:0]      cfg_addr_o,
  input  wire logic [31:0]   cfg_data_i,
  input  wire logic [31:0]   cfg_data_n_i,
  // decoded fields
  output logic [2:0]         boot_sel_o,
  output logic               pri_xtal_o
);

  logic [31:0]   word_r [WORDS];
  logic          busy_r;
  logic          done_r;
  logic          mis_r;
  logic [AW-1:0] idx_r;

  wire logic last = (idx_r == AW'(WORDS - 1));
  // every word is stored with its complement beside it
  wire logic bad  = (cfg_data_n_i != ~cfg_data_i);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < WORDS; i++)
        word_r[i] <= rcs_pkg::CFG_PRESET;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      mis_r  <= 1'b0;
      idx_r  <= '0;
    end
    else
    begin
      done_r <= busy_r & last & ~start_i;
      mis_r  <= busy_r & bad & ~start_i;
      if (start_i)
      begin
        busy_r <= 1'b1;
        idx_r  <= '0;
        // other resets keep the words so debug state survives
        if (preset_i)
          for (int i = 0; i < WORDS; i++)
            word_r[i] <= rcs_pkg::CFG_PRESET;
      end
      else if (busy_r)
      begin
        word_r[idx_r] <= cfg_data_i;
        idx_r         <= idx_r + AW'(1);
        busy_r        <= ~last;
      end
    end
  end

  assign done_o     = done_r;
  assign mismatch_o = mis_r;
  assign cfg_rd_o   = busy_r;
  assign cfg_addr_o = idx_r;
  assign boot_sel_o = word_r[rcs_pkg::CFG_CLK_WORD][rcs_pkg::CLKSEL_LSB +: 3];
  assign pri_xtal_o = word_r[rcs_pkg::CFG_CLK_WORD][rcs_pkg::XTAL_BIT];

endmodule : rcs_cfg_loader
`default_nettype wire

// File: verilog/rcs_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module rcs_reset_ctrl #(
  parameter int          ADR_W     = 4,
  parameter int          CFG_WORDS = rcs_pkg::CFG_WORDS,
  parameter int          PWRT_CYC  = rcs_pkg::PWRT_CYC,
  parameter int          VREG_CYC  = rcs_pkg::VREG_CYC,
  parameter int          LOCK_CYC  = rcs_pkg::LOCK_CYC,
  parameter int          OST_CYC   = rcs_pkg::OST_CYC,
  parameter int          FSCM_CYC  = rcs_pkg::FSCM_CYC,
  parameter logic [31:0] IRQ_VEC   = rcs_pkg::IRQ_VECTOR,
  localparam int         CFG_AW    = (CFG_WORDS > 1) ? $clog2(CFG_WORDS) : 1
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_b_i,
  // wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADR_W-1:0]  wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  // reset sources
  input  wire logic              por_i,
  input  wire logic              brownout_i,
  input  wire logic              external_reset_pin_b_i,
  input  wire logic              watchdog_timeout_i,
  input  wire logic              regulator_en_i,
  // core side
  input  wire logic              wait_exec_i,
  input  wire logic              wait_sleep_i,
  input  wire logic              wake_irq_i,
  output logic                   core_hold_o,
  output logic                   core_wake_o,
  output logic [31:0]            core_pc_o,
  output logic [2:0]             core_clk_sel_o,
  // configuration store
  output logic                   cfg_rd_o,
  output logic [CFG_AW-1:0]      cfg_addr_o,
  input  wire logic [31:0]       cfg_data_i,
  input  wire logic [31:0]       cfg_data_n_i
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_s1_r;
  logic rst_n;

  always_ff @(posedge clk_sys_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_s1_r <= 1'b0;
      rst_n    <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n    <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state

  rcs_pkg::rcs_state_t state_r;
  rcs_pkg::rcs_state_t state_nxt;
  rcs_pkg::rcs_lp_t    lp_r;
  rcs_pkg::rcs_lp_t    lp_nxt;
  logic [31:0]         cnt_r;
  logic [31:0]         cnt_nxt;
  logic [31:0]         flags_r;
  logic [31:0]         flags_nxt;
  logic                pwr_r;
  logic                pwr_nxt;
  logic                full_r;
  logic                full_nxt;
  logic                ld_start;
  logic                ack_r;
  logic [31:0]         dat_r;
  logic                arm_r;
  logic                soft_trig_r;
  logic                wake_r;
  logic [31:0]         pc_r;
  logic [2:0]          clk_sel_r;
  logic                ld_done;
  logic                mism_p;
  logic [2:0]          boot_sel;
  logic                pri_xtal;

  ////////////////////////////////////////////////////////////////////////////
  // source decode

  wire logic run_st    = (state_r == rcs_pkg::ST_RUN);
  wire logic pin_act   = ~external_reset_pin_b_i;
  wire logic lp_on     = (lp_r != rcs_pkg::LP_RUN);
  wire logic wait_go   = wait_exec_i & run_st;
  wire logic wake_irq  = wake_irq_i & run_st & lp_on;
  // timeout in low power only wakes the core, no device reset
  wire logic wdt_wake  = watchdog_timeout_i & run_st & lp_on;
  wire logic wdt_rst   = watchdog_timeout_i & ~wdt_wake;
  wire logic hold_lv   = por_i | brownout_i | pin_act;
  wire logic src_any   = hold_lv | wdt_rst | mism_p | soft_trig_r;

  ////////////////////////////////////////////////////////////////////////////
  // wishbone decode

  wire logic        wb_req    = wb_cyc_i & wb_stb_i;
  wire logic [3:0]  wb_off    = {wb_adr_i[3:2], 2'h0};
  wire logic        hit_flags = (wb_off == rcs_pkg::REG_FLAGS);
  wire logic        hit_soft  = (wb_off == rcs_pkg::REG_SOFT);
  wire logic        hit_stat  = (wb_off == rcs_pkg::REG_STAT);
  wire logic        wr_fire   = wb_req & wb_we_i & ack_r;
  wire logic        rd_fire   = wb_req & ~wb_we_i & ack_r;
  wire logic [31:0] lane_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic [31:0] wmask     = lane_mask & rcs_pkg::FLAGS_WMASK;
  wire logic [31:0] stat_word = 32'(state_r)
                              | (32'(lp_r) << rcs_pkg::STAT_LP_LSB)
                              | (32'(clk_sel_r) << rcs_pkg::STAT_CLK_LSB);
  wire logic [31:0] rd_mux    = hit_flags ? flags_r
                              : hit_soft  ? {31'h0, arm_r}
                              : hit_stat  ? stat_word
                              : 32'h0;

  ////////////////////////////////////////////////////////////////////////////
  // clock source dependent delay

  wire logic        src_pll  = (boot_sel == rcs_pkg::CLK_FRCPLL)
                             | (boot_sel == rcs_pkg::CLK_PRIPLL);
  wire logic        src_xtal = (boot_sel == rcs_pkg::CLK_SOSC) | (pri_xtal &
                               ((boot_sel == rcs_pkg::CLK_PRI) |
                                (boot_sel == rcs_pkg::CLK_PRIPLL)));
  wire logic [31:0] clk_cyc  = (src_pll ? 32'(LOCK_CYC) : 32'h0)
                             + (src_xtal ? 32'(OST_CYC) : 32'h0)
                             + ((src_pll | src_xtal) ? 32'(FSCM_CYC) : 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // cause flags

  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_fire && hit_flags)
      flags_nxt = (flags_r & ~wmask) | (wb_dat_i & wmask);
    if (wait_go && wait_sleep_i)
      flags_nxt[rcs_pkg::FLG_SLEEP] = 1'b1;
    if (wait_go && !wait_sleep_i)
      flags_nxt[rcs_pkg::FLG_IDLE] = 1'b1;
    if (por_i)
      flags_nxt = rcs_pkg::FLAGS_RST;
    else if (brownout_i)
    begin
      flags_nxt = flags_nxt & rcs_pkg::FLAGS_KEEP_PON;
      flags_nxt[rcs_pkg::FLG_BROWN] = 1'b1;
    end
    // hardware sets come last so they beat a software clear
    // sleep and idle are left alone here, kept from the wait
    if (pin_act)
      flags_nxt[rcs_pkg::FLG_PIN] = 1'b1;
    if (soft_trig_r)
      flags_nxt[rcs_pkg::FLG_SOFT] = 1'b1;
    if (mism_p)
      flags_nxt[rcs_pkg::FLG_MISM] = 1'b1;
    if (watchdog_timeout_i)
      flags_nxt[rcs_pkg::FLG_WDOG] = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // low power tracking

  always_comb
  begin
    lp_nxt = lp_r;
    if (!run_st || src_any || wake_irq || wdt_wake)
      lp_nxt = rcs_pkg::LP_RUN;
    else if (wait_go)
      lp_nxt = wait_sleep_i ? rcs_pkg::LP_SLEEP : rcs_pkg::LP_IDLE;
  end

  ////////////////////////////////////////////////////////////////////////////
  // release sequencer

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = (cnt_r != 32'h0) ? cnt_r - 32'h1 : cnt_r;
    pwr_nxt   = pwr_r;
    full_nxt  = full_r;
    ld_start  = 1'b0;
    case (state_r)
      rcs_pkg::ST_RUN:
        state_nxt = rcs_pkg::ST_RUN;
      rcs_pkg::ST_HOLD:
        if (!hold_lv)
        begin
          if (pwr_r)
          begin
            state_nxt = rcs_pkg::ST_PWRUP;
            cnt_nxt   = 32'(regulator_en_i ? VREG_CYC - 1 : PWRT_CYC - 1);
          end
          else
          begin
            state_nxt = rcs_pkg::ST_LOAD;
            ld_start  = 1'b1;
          end
        end
      rcs_pkg::ST_PWRUP:
        if (cnt_r == 32'h0)
        begin
          state_nxt = rcs_pkg::ST_LOAD;
          ld_start  = 1'b1;
        end
      rcs_pkg::ST_LOAD:
        if (ld_done)
        begin
          if (full_r && clk_cyc != 32'h0)
          begin
            state_nxt = rcs_pkg::ST_CLKDLY;
            cnt_nxt   = clk_cyc - 32'h1;
          end
          else
          begin
            state_nxt = rcs_pkg::ST_SYSDLY;
            cnt_nxt   = 32'(rcs_pkg::SYSDLY_CLKS - 1);
          end
        end
      rcs_pkg::ST_CLKDLY:
        if (cnt_r == 32'h0)
        begin
          state_nxt = rcs_pkg::ST_SYSDLY;
          cnt_nxt   = 32'(rcs_pkg::SYSDLY_CLKS - 1);
        end
      rcs_pkg::ST_SYSDLY:
        if (cnt_r == 32'h0)
        begin
          state_nxt = rcs_pkg::ST_RUN;
          pwr_nxt   = 1'b0;
          full_nxt  = 1'b0;
        end
      default:
        state_nxt = rcs_pkg::ST_HOLD;
    endcase
    // any source restarts the sequence; strongest kind seen is kept
    if (src_any)
    begin
      state_nxt = rcs_pkg::ST_HOLD;
      ld_start  = 1'b0;
      pwr_nxt   = pwr_r | por_i;
      full_nxt  = full_r | por_i | brownout_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= rcs_pkg::ST_HOLD;
      lp_r    <= rcs_pkg::LP_RUN;
      cnt_r   <= 32'h0;
      flags_r <= rcs_pkg::FLAGS_RST;
      pwr_r   <= 1'b1;
      full_r  <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      lp_r    <= lp_nxt;
      cnt_r   <= cnt_nxt;
      flags_r <= flags_nxt;
      pwr_r   <= pwr_nxt;
      full_r  <= full_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus, soft reset and core outputs

  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_r      <= 1'b0;
      dat_r      <= 32'h0;
      arm_r      <= 1'b0;
      soft_trig_r <= 1'b0;
      wake_r     <= 1'b0;
      pc_r       <= rcs_pkg::RESET_VECTOR;
      clk_sel_r  <= rcs_pkg::CLK_SEL_RST;
    end
    else
    begin
      ack_r <= wb_req & ~ack_r;
      if (wb_req && !ack_r)
        dat_r <= rd_mux;
      if (!run_st)
        arm_r <= 1'b0;
      else if (wr_fire && hit_soft && wb_sel_i[0])
        arm_r <= wb_dat_i[0];
      soft_trig_r <= rd_fire & hit_soft & arm_r & run_st;
      wake_r      <= (wake_irq | wdt_wake) & ~src_any;
      // vector set on the same edge the hold begins
      if (!run_st || src_any || wdt_wake)
        pc_r <= rcs_pkg::RESET_VECTOR;
      else if (wake_irq)
        pc_r <= IRQ_VEC;
      if (state_r == rcs_pkg::ST_LOAD && ld_done)
        clk_sel_r <= boot_sel;
    end
  end

  rcs_cfg_loader #(
    .WORDS (CFG_WORDS),
    .AW    (CFG_AW)
  ) u_loader (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n),
    .start_i      (ld_start),
    .preset_i     (pwr_r),
    .done_o       (ld_done),
    .mismatch_o   (mism_p),
    .cfg_rd_o     (cfg_rd_o),
    .cfg_addr_o   (cfg_addr_o),
    .cfg_data_i   (cfg_data_i),
    .cfg_data_n_i (cfg_data_n_i),
    .boot_sel_o   (boot_sel),
    .pri_xtal_o   (pri_xtal)
  );

  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = dat_r;
  assign core_hold_o    = ~run_st;
  assign core_wake_o    = wake_r;
  assign core_pc_o      = pc_r;
  assign core_clk_sel_o = clk_sel_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n);

  wire logic quiet = !wr_fire && !wait_go && !pin_act && !soft_trig_r
                   && !mism_p && !watchdog_timeout_i;
  wire logic in_sys = (state_r == rcs_pkg::ST_SYSDLY);

  sequence s_sys_enter;
    $rose(in_sys);
  endsequence
  sequence s_soft_read;
    rd_fire && hit_soft && arm_r && run_st;
  endsequence

  AST_POR_FLAGS: assert property (
    por_i && quiet |=> flags_r == rcs_pkg::FLAGS_RST && core_pc_o == rcs_pkg::RESET_VECTOR)
    else $error("power-on flags wrong");
  AST_BROWN_FLAGS: assert property (
    brownout_i && !por_i && quiet |=> flags_r[rcs_pkg::FLG_BROWN] && flags_r[31:2] == 30'h0
      && flags_r[rcs_pkg::FLG_POR] == $past(flags_r[rcs_pkg::FLG_POR]))
    else $error("brown-out flags wrong");
  AST_PIN_FLAG: assert property (
    pin_act && !por_i && !brownout_i && !wr_fire && !soft_trig_r && !mism_p
      && !watchdog_timeout_i && !wait_go
    |=> flags_r == ($past(flags_r) | (32'h1 << rcs_pkg::FLG_PIN)))
    else $error("pin reset flag wrong");
  AST_SOFT_RESET: assert property (
    s_soft_read |=> soft_trig_r ##1 (core_hold_o && flags_r[rcs_pkg::FLG_SOFT]))
    else $error("soft reset not triggered");
  AST_HOLD_SRC: assert property (
    hold_lv |=> state_r == rcs_pkg::ST_HOLD && core_hold_o)
    else $error("core released while source active");
  AST_SYS_HOLD: assert property (
    s_sys_enter ##0 (!src_any)[*7] |-> core_hold_o)
    else $error("released before eight clocks");
  AST_SYS_REL: assert property (
    s_sys_enter ##0 (!src_any)[*8] |=> !core_hold_o && $past(core_hold_o))
    else $error("not released after eight clocks");
  AST_WDT_WAKE: assert property (
    wdt_wake && !src_any |=> core_wake_o && !core_hold_o
      && core_pc_o == rcs_pkg::RESET_VECTOR && flags_r[rcs_pkg::FLG_WDOG])
    else $error("watchdog wake wrong");
  AST_IRQ_WAKE: assert property (
    wake_irq && !src_any && quiet |=> core_wake_o && core_pc_o == IRQ_VEC
      && flags_r == $past(flags_r))
    else $error("interrupt wake wrong");
  AST_CLK_RESEL: assert property (
    state_r == rcs_pkg::ST_LOAD && ld_done |=> core_clk_sel_o == $past(boot_sel))
    else $error("clock not reselected");
  AST_WAIT_FLAG: assert property (
    wait_go && !por_i && !brownout_i |=> ($past(wait_sleep_i)
      ? flags_r[rcs_pkg::FLG_SLEEP] : flags_r[rcs_pkg::FLG_IDLE]))
    else $error("low power flag not set");

endmodule : rcs_reset_ctrl
`default_nettype wire

// File: tb/rcs_store_model.sv
`timescale 1ns/1ns
`default_nettype none
module rcs_store_model (
  // read port
  input  wire logic        clk_sys_i,
  input  wire logic        rd_i,
  input  wire logic [1:0]  addr_i,
  // stored clock code and fault injection
  input  wire logic [2:0]  clk_code_i,
  input  wire logic        bad_i,
  // word and its complement
  output logic [31:0]      data_o,
  output logic [31:0]      data_n_o
);
  logic [31:0] word;
  logic        tog_r = 1'b0;

  assign word = (addr_i == 2'h1) ? {29'h0, clk_code_i} : {30'h0, addr_i};
  // lines outside a read toggle so stale data never looks valid
  always_ff @(posedge clk_sys_i) tog_r <= ~tog_r;
  assign data_o   = rd_i ? word : {32{tog_r}};
  assign data_n_o = rd_i ? (bad_i ? word : ~word) : {32{tog_r}};
endmodule : rcs_store_model
`default_nettype wire

// File: tb/tb_rcs_reset_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_rcs_reset_ctrl;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pin_b = 1'b1, wdt = 1'b0, bor = 1'b0;
  logic        reg_en = 1'b0, wexe = 1'b0, wslp = 1'b0, irq = 1'b0, bad = 1'b0, seen = 1'b0;
  logic        por = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'hF;
  logic [31:0] dat = 32'h0, rdat, dn, rnd, exp_v;
  logic [31:0] wb_dat_o, core_pc_o;
  logic        wb_ack_o, core_hold_o, core_wake_o, cfg_rd_o;
  logic [2:0]  core_clk_sel_o, clk_code = 3'h0;
  logic [1:0]  cfg_addr;
  logic [31:0] expq[$];
  int          err_count = 0, checks_done = 0, cyc_n = 0;
  localparam logic [31:0] F_PIN  = 32'h1 << rcs_pkg::FLG_PIN;
  localparam logic [31:0] F_WDOG = 32'h1 << rcs_pkg::FLG_WDOG;

  rcs_reset_ctrl #(.PWRT_CYC(50), .VREG_CYC(10), .LOCK_CYC(10), .OST_CYC(20), .FSCM_CYC(5))
  rcs_reset_ctrl_i (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .por_i(por), .brownout_i(bor), .external_reset_pin_b_i(pin_b),
    .watchdog_timeout_i(wdt), .regulator_en_i(reg_en), .wait_exec_i(wexe),
    .wait_sleep_i(wslp), .wake_irq_i(irq), .core_hold_o(core_hold_o),
    .core_wake_o(core_wake_o), .core_pc_o(core_pc_o), .core_clk_sel_o(core_clk_sel_o),
    .cfg_rd_o(cfg_rd_o), .cfg_addr_o(cfg_addr), .cfg_data_i(rdat), .cfg_data_n_i(dn));

  rcs_store_model rcs_store_model_i (.clk_sys_i(clk_sys_i), .rd_i(cfg_rd_o), .addr_i(cfg_addr),
    .clk_code_i(clk_code), .bad_i(bad), .data_o(rdat), .data_n_o(dn));

  always #10 clk_sys_i = ~clk_sys_i;

  ////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize

  always @(posedge clk_sys_i)
  begin
    cyc_n++;
    if (cfg_rd_o === 1'b1)
      seen = 1'b1;
    if (wb_ack_o === 1'b1 && !we && expq.size() > 0)
    begin
      exp_v = expq.pop_front();
      `CHK("rdata", exp_v, wb_dat_o)
    end
    if (cyc_n > 6000)
    begin
      err_count++;
      summarize();
    end
  end

  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge clk_sys_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= s;
    dat <= d;
    if (!w)
      expq.push_back(d);
    // wb_ack_o ends this wait; without it only the bench timeout does
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // waits out a reset sequence and confirms the configuration was reloaded
  task automatic settle;
    int n;
    n = 0;
    repeat (3) @(posedge clk_sys_i);
    while (core_hold_o !== 1'b0 && n++ < 3000) @(posedge clk_sys_i);
    `CHK("released", 1'b0, core_hold_o)
    `CHK("reload", 1'b1, seen)
    `CHK("clksel", clk_code, core_clk_sel_o)
    seen = 1'b0;
  endtask : settle

  task automatic lp(input logic slp);
    @(posedge clk_sys_i);
    wexe <= 1'b1;
    wslp <= slp;
    @(posedge clk_sys_i);
    wexe <= 1'b0;
  endtask : lp

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rnd = $urandom(32'h212C);
    clk_code <= 3'($urandom % 5);
    reg_en   <= 1'($urandom);
    repeat (4) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    settle();
    `CHK("pc", rcs_pkg::RESET_VECTOR, core_pc_o)
    wb(rcs_pkg::REG_FLAGS, 0, rcs_pkg::FLAGS_RST);
    wb(4'hC, 0, 32'h0);
    rnd = $urandom;
    wb(rcs_pkg::REG_FLAGS, 1, rnd);
    `CHK("nohold", 1'b0, core_hold_o)
    wb(rcs_pkg::REG_FLAGS, 0, rnd & rcs_pkg::FLAGS_WMASK);
    wb(rcs_pkg::REG_FLAGS, 1, 32'h0);
    wb(rcs_pkg::REG_FLAGS, 1, rcs_pkg::FLAGS_WMASK, 4'h1);
    wb(rcs_pkg::REG_FLAGS, 0, rcs_pkg::FLAGS_WMASK & 32'hFF);
    wb(rcs_pkg::REG_FLAGS, 1, 32'h0);
    lp(1'b0);
    pin_b <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    pin_b <= 1'b1;
    settle();
    wb(rcs_pkg::REG_FLAGS, 0, F_PIN | 32'h4);
    wb(rcs_pkg::REG_FLAGS, 1, 32'h0);
    wb(rcs_pkg::REG_SOFT, 1, 32'h1);
    wb(rcs_pkg::REG_SOFT, 0, 32'h1);
    repeat (3) @(posedge clk_sys_i);
    `CHK("softhold", 1'b1, core_hold_o)
    settle();
    wb(rcs_pkg::REG_FLAGS, 0, 32'h1 << rcs_pkg::FLG_SOFT);
    wb(rcs_pkg::REG_FLAGS, 1, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      if (i > 0)
        lp(1'(2 - i));
      @(posedge clk_sys_i);
      wdt <= (i < 2);
      irq <= (i == 2);
      @(posedge clk_sys_i);
      wdt <= 1'b0;
      irq <= 1'b0;
      #1;
      if (i > 0)
      begin
        `CHK("wake", 1'b1, core_wake_o)
        `CHK("wpc", (i == 1) ? rcs_pkg::RESET_VECTOR : rcs_pkg::IRQ_VECTOR, core_pc_o)
        `CHK("nohold", 1'b0, core_hold_o)
      end
      else
        settle();
      wb(rcs_pkg::REG_FLAGS, 0, (i == 0) ? F_WDOG : (i == 1) ? 32'h18 : 32'h4);
      wb(rcs_pkg::REG_FLAGS, 1, 32'h0);
    end
    for (int i = 0; i < 2; i++)
    begin
      wb(rcs_pkg::REG_FLAGS, 1, rcs_pkg::FLAGS_WMASK ^ i);
      bor <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      bor <= 1'b0;
      settle();
      wb(rcs_pkg::REG_FLAGS, 0, 32'h3 ^ i);
    end
    wb(rcs_pkg::REG_FLAGS, 1, 32'h0);
    bad   <= 1'b1;
    pin_b <= 1'b0;
    wdt   <= 1'b1;
    @(posedge clk_sys_i);
    wdt <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    `CHK("multihold", 1'b1, core_hold_o)
    pin_b <= 1'b1;
    for (int n = 0; n < 200 && cfg_rd_o !== 1'b1; n++) @(posedge clk_sys_i);
    bad <= 1'b0;
    settle();
    wb(rcs_pkg::REG_FLAGS, 0, F_PIN | F_WDOG | (32'h1 << rcs_pkg::FLG_MISM));
    por <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    por <= 1'b0;
    settle();
    `CHK("porpc", rcs_pkg::RESET_VECTOR, core_pc_o)
    wb(rcs_pkg::REG_FLAGS, 0, rcs_pkg::FLAGS_RST);
    repeat (2) @(posedge clk_sys_i);
    summarize();
  end
endmodule : tb_rcs_reset_ctrl
`default_nettype wire
